// >>> core/ssfi_pkg.sv
// Shared constants and types of the serial slave frame interface
package ssfi_pkg;

    localparam int unsigned FRAME_W   = 16;
    localparam int unsigned ADDR_W    = 3;
    localparam int unsigned DATA_W    = 12;
    localparam int unsigned REG_COUNT = 8;
    localparam int unsigned BIT_CNT_W = 3;

    // Field positions of request and response frames
    localparam int unsigned RW_BIT          = 15;
    localparam int unsigned PARITY_FLAG_BIT = 15;
    localparam int unsigned ADDR_HI         = 14;
    localparam int unsigned ADDR_LO         = 12;
    localparam int unsigned DATA_HI         = 11;
    localparam int unsigned DATA_LO         = 0;

    localparam logic [ADDR_W-1:0] CMD_ADDR             = 3'h0;
    localparam logic [DATA_W-1:0] NOP_CMD              = 12'h000;
    localparam logic [DATA_W-1:0] READ_DIAG_STATUS_CMD = 12'h5a1;
    localparam logic [DATA_W-1:0] REG_RESET            = 12'h000;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_RESET     = 3'h0;

    // Host-side timing figures, kept for reference by firmware models
    localparam int unsigned CLK_FREQ_KHZ        = 10000;
    localparam int unsigned OSC_TYP_KHZ         = 500;
    localparam int unsigned DIAG_CLEAR_READ_US  = 16;
    localparam int unsigned OC_CLEAR_GAP_US     = 12;
    localparam int unsigned DIAG_CLEAR_READ_CYC = (DIAG_CLEAR_READ_US * CLK_FREQ_KHZ + 999) / 1000;
    localparam int unsigned OC_CLEAR_GAP_CYC    = (OC_CLEAR_GAP_US * CLK_FREQ_KHZ + 999) / 1000;

    typedef enum logic {
        LINK_IDLE,
        LINK_FRAME
    } ssfi_link_state_t;

endpackage

// >>> core/ssfi_buf2.sv
// Two-entry valid/ready buffer between frame capture and command execution
`timescale 1ns/100ps
`default_nettype none

module ssfi_buf2 #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);

    logic [WIDTH-1:0] slot_reg [2];
    logic [WIDTH-1:0] slot_next [2];
    logic [1:0]       count_reg;
    logic [1:0]       count_next;
    logic             push;
    logic             pop;

    assign o_in_ready  = (count_reg != 2'h2);
    assign o_out_valid = (count_reg != 2'h0);
    assign o_out_data  = slot_reg[0];

    always_comb begin
        push       = i_in_valid && o_in_ready;
        pop        = o_out_valid && i_out_ready;
        slot_next  = slot_reg;
        count_next = count_reg;
        if (pop) begin
            slot_next[0] = slot_reg[1];
        end
        if (push) begin
            // Entry lands behind whatever stays after a pop
            if (count_reg == 2'h0 || (count_reg == 2'h1 && pop)) begin
                slot_next[0] = i_in_data;
            end else begin
                slot_next[1] = i_in_data;
            end
        end
        count_next = count_reg + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            count_reg   <= 2'h0;
            slot_reg[0] <= '0;
            slot_reg[1] <= '0;
        end else begin
            count_reg <= count_next;
            slot_reg  <= slot_next;
        end
    end

endmodule

`default_nettype wire

// >>> core/ssfi_core.sv
// Serial slave frame interface: pin capture, framing, decode and response
`timescale 1ns/100ps
`default_nettype none

module ssfi_core (
    input  wire logic                                    i_clock,
    input  wire logic                                    i_rst,
    input  wire logic                                    i_cs_n,
    input  wire logic                                    i_sclk,
    input  wire logic                                    i_si,
    input  wire logic [ssfi_pkg::DATA_W-1:0]             i_diag_status,
    input  wire logic                                    i_exec_hold,
    output logic                                         o_so,
    output logic                                         o_so_oe,
    output logic [ssfi_pkg::REG_COUNT*ssfi_pkg::DATA_W-1:0] o_reg_flat,
    output logic                                         o_wr_strobe,
    output logic [ssfi_pkg::ADDR_W-1:0]                  o_wr_addr,
    output logic                                         o_comm_error
);

    localparam int unsigned FW = ssfi_pkg::FRAME_W;
    localparam int unsigned AW = ssfi_pkg::ADDR_W;
    localparam int unsigned DW = ssfi_pkg::DATA_W;

    // Pin synchronisers: stage 0 is read only by stage 1
    logic [1:0] cs_sync_reg,   cs_sync_next;
    logic [1:0] sclk_sync_reg, sclk_sync_next;
    logic [1:0] si_sync_reg,   si_sync_next;
    logic       cs_prev_reg,   cs_prev_next;
    logic       sclk_prev_reg, sclk_prev_next;
    ssfi_pkg::ssfi_link_state_t state_reg, state_next;
    logic [FW-1:0]                   shift_reg, shift_next;
    logic                            si_lat_reg, si_lat_next;
    logic [ssfi_pkg::BIT_CNT_W-1:0]  cnt_reg, cnt_next;
    logic                            any_reg, any_next;
    logic                            so_reg, so_next;
    logic                            oe_reg, oe_next;

    logic          cs_fall, cs_rise, sclk_fall, sclk_rise;
    logic          frame_ok, frame_err;
    logic [FW-1:0] rx_word, tx_word;
    logic [FW-2:0] tx_payload;
    logic          buf_in_valid, buf_in_ready;
    logic          buf_out_valid, buf_out_ready;
    logic [FW-1:0] buf_out_data;
    logic          exec_fire;
    logic [DW-1:0] regs_reg [ssfi_pkg::REG_COUNT];
    logic [DW-1:0] regs_next [ssfi_pkg::REG_COUNT];
    logic [AW-1:0] resp_addr_reg, resp_addr_next;
    logic [DW-1:0] resp_data_reg, resp_data_next;
    logic          diag_sel_reg, diag_sel_next;
    logic          err_reg, err_next;
    logic          wr_reg, wr_next;
    logic [AW-1:0] wr_addr_reg, wr_addr_next;
    logic          cmd_err, err_clear;
    logic [AW-1:0] x_addr;
    logic [DW-1:0] x_data;

    // Edge detection after two-stage sync on the core clock
    assign cs_fall   = cs_prev_reg && !cs_sync_reg[1];
    assign cs_rise   = !cs_prev_reg && cs_sync_reg[1];
    assign sclk_fall = sclk_prev_reg && !sclk_sync_reg[1];
    assign sclk_rise = !sclk_prev_reg && sclk_sync_reg[1];

    // Short diagnosis is taken live at load so it reflects current state
    assign tx_payload = diag_sel_reg ? {ssfi_pkg::CMD_ADDR, i_diag_status}
                                     : {resp_addr_reg, resp_data_reg};
    assign tx_word    = {^tx_payload, tx_payload};
    assign rx_word    = {shift_reg[FW-2:0], si_lat_reg};
    assign frame_ok   = any_reg && (cnt_reg == ssfi_pkg::BIT_CNT_RESET);

    always_comb begin
        cs_sync_next   = {cs_sync_reg[0], i_cs_n};
        sclk_sync_next = {sclk_sync_reg[0], i_sclk};
        si_sync_next   = {si_sync_reg[0], i_si};
        cs_prev_next   = cs_sync_reg[1];
        sclk_prev_next = sclk_sync_reg[1];
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cs_sync_reg   <= 2'h3;
            sclk_sync_reg <= 2'h0;
            si_sync_reg   <= 2'h0;
            cs_prev_reg   <= 1'b1;
            sclk_prev_reg <= 1'b0;
        end else begin
            cs_sync_reg   <= cs_sync_next;
            sclk_sync_reg <= sclk_sync_next;
            si_sync_reg   <= si_sync_next;
            cs_prev_reg   <= cs_prev_next;
            sclk_prev_reg <= sclk_prev_next;
        end
    end

    // Frame engine: one shifter serves as a chain stage
    always_comb begin
        state_next   = state_reg;
        shift_next   = shift_reg;
        si_lat_next  = si_lat_reg;
        cnt_next     = cnt_reg;
        any_next     = any_reg;
        so_next      = so_reg;
        oe_next      = oe_reg;
        buf_in_valid = 1'b0;
        frame_err    = 1'b0;
        case (state_reg)
            ssfi_pkg::LINK_IDLE: begin
                oe_next = 1'b0;
                if (cs_fall) begin
                    shift_next = tx_word;
                    so_next    = tx_word[FW-1];
                    oe_next    = 1'b1;
                    cnt_next   = ssfi_pkg::BIT_CNT_RESET;
                    any_next   = 1'b0;
                    state_next = ssfi_pkg::LINK_FRAME;
                end
            end
            ssfi_pkg::LINK_FRAME: begin
                if (cs_rise) begin
                    oe_next    = 1'b0;
                    state_next = ssfi_pkg::LINK_IDLE;
                    // A full buffer also loses the frame, so it counts as an error
                    if (frame_ok && buf_in_ready) begin
                        buf_in_valid = 1'b1;
                    end else begin
                        frame_err = 1'b1;
                    end
                end else if (sclk_fall) begin
                    si_lat_next = si_sync_reg[1];
                    cnt_next    = cnt_reg + 3'h1;
                    any_next    = 1'b1;
                end else if (sclk_rise) begin
                    shift_next = {shift_reg[FW-2:0], si_lat_reg};
                    so_next    = shift_reg[FW-2];
                end
            end
            default: begin
                state_next = ssfi_pkg::LINK_IDLE;
                oe_next    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_reg  <= ssfi_pkg::LINK_IDLE;
            shift_reg  <= '0;
            si_lat_reg <= 1'b0;
            cnt_reg    <= ssfi_pkg::BIT_CNT_RESET;
            any_reg    <= 1'b0;
            so_reg     <= 1'b0;
            oe_reg     <= 1'b0;
        end else begin
            state_reg  <= state_next;
            shift_reg  <= shift_next;
            si_lat_reg <= si_lat_next;
            cnt_reg    <= cnt_next;
            any_reg    <= any_next;
            so_reg     <= so_next;
            oe_reg     <= oe_next;
        end
    end

    ssfi_buf2 #(
        .WIDTH (FW)
    ) u_frame_buf (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_in_valid  (buf_in_valid),
        .o_in_ready  (buf_in_ready),
        .i_in_data   (rx_word),
        .o_out_valid (buf_out_valid),
        .i_out_ready (buf_out_ready),
        .o_out_data  (buf_out_data)
    );

    assign buf_out_ready = !i_exec_hold;
    assign exec_fire     = buf_out_valid && buf_out_ready;
    assign x_addr        = buf_out_data[ssfi_pkg::ADDR_HI:ssfi_pkg::ADDR_LO];
    assign x_data        = buf_out_data[ssfi_pkg::DATA_HI:ssfi_pkg::DATA_LO];

    // Command executor; its answer is what the next frame carries out
    always_comb begin
        regs_next      = regs_reg;
        resp_addr_next = resp_addr_reg;
        resp_data_next = resp_data_reg;
        diag_sel_next  = diag_sel_reg;
        wr_next        = 1'b0;
        wr_addr_next   = wr_addr_reg;
        cmd_err        = 1'b0;
        err_clear      = 1'b0;
        if (exec_fire) begin
            diag_sel_next = 1'b1;
            if (buf_out_data[ssfi_pkg::RW_BIT]) begin
                if (x_addr == ssfi_pkg::CMD_ADDR) begin
                    if (x_data == ssfi_pkg::READ_DIAG_STATUS_CMD) begin
                        diag_sel_next  = 1'b0;
                        resp_addr_next = ssfi_pkg::CMD_ADDR;
                        resp_data_next = {err_reg, i_diag_status[DW-2:0]};
                        err_clear      = 1'b1;
                    end else if (x_data != ssfi_pkg::NOP_CMD) begin
                        // Compact commands are not decoded here: flagged as unknown
                        cmd_err = 1'b1;
                    end
                end else begin
                    regs_next[x_addr] = x_data;
                    wr_next           = 1'b1;
                    wr_addr_next      = x_addr;
                end
            end else if (x_addr != ssfi_pkg::CMD_ADDR) begin
                diag_sel_next  = 1'b0;
                resp_addr_next = x_addr;
                resp_data_next = regs_reg[x_addr];
            end
        end
        // Set wins over clear
        err_next = (err_reg && !err_clear) || frame_err || cmd_err;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            for (int i = 0; i < ssfi_pkg::REG_COUNT; i++) begin
                regs_reg[i] <= ssfi_pkg::REG_RESET;
            end
            resp_addr_reg <= ssfi_pkg::CMD_ADDR;
            resp_data_reg <= ssfi_pkg::REG_RESET;
            diag_sel_reg  <= 1'b1;
            err_reg       <= 1'b0;
            wr_reg        <= 1'b0;
            wr_addr_reg   <= ssfi_pkg::CMD_ADDR;
        end else begin
            regs_reg      <= regs_next;
            resp_addr_reg <= resp_addr_next;
            resp_data_reg <= resp_data_next;
            diag_sel_reg  <= diag_sel_next;
            err_reg       <= err_next;
            wr_reg        <= wr_next;
            wr_addr_reg   <= wr_addr_next;
        end
    end

    for (genvar g = 0; g < ssfi_pkg::REG_COUNT; g++) begin : g_reg_out
        assign o_reg_flat[g*DW +: DW] = regs_reg[g];
    end

    assign o_so         = so_reg;
    assign o_so_oe      = oe_reg;
    assign o_wr_strobe  = wr_reg;
    assign o_wr_addr    = wr_addr_reg;
    assign o_comm_error = err_reg;

    property p_idle_tristate;
        @(posedge i_clock) disable iff (i_rst)
        (state_reg == ssfi_pkg::LINK_IDLE) && !cs_fall |=> !o_so_oe;
    endproperty
    a_idle_tristate: assert property (p_idle_tristate)
        else $error("Serial output driven outside a frame");
    property p_load_parity;
        @(posedge i_clock) disable iff (i_rst)
        (state_reg == ssfi_pkg::LINK_IDLE) && cs_fall
            |=> o_so_oe && (o_so == ^$past(tx_payload)) && (shift_reg == $past(tx_word));
    endproperty
    a_load_parity: assert property (p_load_parity)
        else $error("Frame start did not load response with parity");
    property p_bad_count;
        @(posedge i_clock) disable iff (i_rst)
        (state_reg == ssfi_pkg::LINK_FRAME) && cs_rise && !frame_ok
            |=> o_comm_error && !buf_out_valid [*1];
    endproperty
    a_bad_count: assert property (p_bad_count)
        else $error("Frame with bad bit count was not rejected");
    property p_rise_shift;
        @(posedge i_clock) disable iff (i_rst)
        (state_reg == ssfi_pkg::LINK_FRAME) && !cs_rise && !sclk_fall && sclk_rise
            |=> o_so == $past(shift_reg[FW-2]);
    endproperty
    a_rise_shift: assert property (p_rise_shift)
        else $error("Output bit did not advance on serial clock rise");
    property p_good_exec;
        @(posedge i_clock) disable iff (i_rst)
        (state_reg == ssfi_pkg::LINK_FRAME) && cs_rise && frame_ok && buf_in_ready
            && !buf_out_valid ##1 !i_exec_hold |-> exec_fire;
    endproperty
    a_good_exec: assert property (p_good_exec)
        else $error("Accepted frame was not executed");
    property p_write;
        @(posedge i_clock) disable iff (i_rst)
        exec_fire && buf_out_data[ssfi_pkg::RW_BIT] && (x_addr != ssfi_pkg::CMD_ADDR)
            |=> o_wr_strobe && (o_wr_addr == $past(x_addr))
                && (o_reg_flat[o_wr_addr*DW +: DW] == $past(x_data));
    endproperty
    a_write: assert property (p_write)
        else $error("Write did not update addressed register");
    property p_read;
        @(posedge i_clock) disable iff (i_rst)
        exec_fire && !buf_out_data[ssfi_pkg::RW_BIT] && (x_addr != ssfi_pkg::CMD_ADDR)
            |=> !diag_sel_reg && (tx_payload[FW-2:DW] == $past(x_addr));
    endproperty
    a_read: assert property (p_read)
        else $error("Read response does not echo address");
    property p_reset_diag;
        @(posedge i_clock) disable iff (i_rst)
        $past(i_rst) |-> diag_sel_reg && !o_so_oe && !o_comm_error;
    endproperty
    a_reset_diag: assert property (p_reset_diag)
        else $error("First response after reset is not short diagnosis");

endmodule

`default_nettype wire

// >>> tb/ssfi_master.sv
// Serial master model that drives frames into the slave pins
`timescale 1ns/100ps
`default_nettype none

module ssfi_master (
    input  wire logic i_clock,
    input  wire logic i_so,
    input  wire logic i_so_oe,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_si
);
    // Pull-up on chip select, pull-down on clock and data
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_si   = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    // Sample before each rise so the bit after the last rise has settled
    task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = 32'h0;
        o_cs_n = 1'b0;
        tick(8);
        for (int i = n - 1; i >= 0; i--) begin
            rx[i] = (i_so_oe === 1'b1) ? i_so : 1'bx;
            o_sclk = 1'b1;
            o_si = tx[i];
            tick(4);
            o_sclk = 1'b0;
            tick(4);
        end
        o_cs_n = 1'b1;
        o_si = 1'b0;
        tick(12);
    endtask

    // Pin activity while deselected
    task automatic wiggle();
        for (int i = 0; i < 6; i++) begin
            o_sclk = ~o_sclk;
            o_si = ~o_si;
            tick(4);
        end
    endtask
endmodule

`default_nettype wire

// >>> tb/test_spi_slave_frame_interface.sv
// Self-checking bench for the serial slave frame interface
`timescale 1ns/100ps
`default_nettype none

module test_spi_slave_frame_interface;
    logic        i_clock;
    logic        i_rst;
    logic        cs_n;
    logic        sclk;
    logic        si;
    logic [11:0] diag;
    logic        hold;
    logic        so;
    logic        so_oe;
    logic [95:0] regs;
    logic        wr_strobe;
    logic [2:0]  wr_addr;
    logic        comm_err;
    logic [31:0] rx;
    logic [2:0]  a;
    logic [11:0] d;
    logic [11:0] exp_reg [8];
    int          mismatches;
    int          compares;
    int          cycles;
    int          strobes;

    ssfi_core DUT (
        .i_clock       (i_clock),
        .i_rst         (i_rst),
        .i_cs_n        (cs_n),
        .i_sclk        (sclk),
        .i_si          (si),
        .i_diag_status (diag),
        .i_exec_hold   (hold),
        .o_so          (so),
        .o_so_oe       (so_oe),
        .o_reg_flat    (regs),
        .o_wr_strobe   (wr_strobe),
        .o_wr_addr     (wr_addr),
        .o_comm_error  (comm_err)
    );

    ssfi_master master (
        .i_clock (i_clock),
        .i_so    (so),
        .i_so_oe (so_oe),
        .o_cs_n  (cs_n),
        .o_sclk  (sclk),
        .o_si    (si)
    );

    initial i_clock = 1'b0;
    always #50 i_clock = ~i_clock;

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Whole run needs about 4400 cycles
    always @(posedge i_clock) begin
        cycles++;
        if (wr_strobe === 1'b1) begin
            strobes++;
        end
        if (cycles == 30000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic check(input logic [95:0] got, input logic [95:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] resp(input logic [2:0] ad, input logic [11:0] dt);
        return {^{ad, dt}, ad, dt};
    endfunction

    function automatic logic [95:0] flat();
        logic [95:0] f;
        for (int k = 0; k < 8; k++) f[k*12 +: 12] = exp_reg[k];
        return f;
    endfunction

    task automatic wr(input logic [2:0] ad, input logic [11:0] dt);
        master.frame(16, {16'h0000, 1'b1, ad, dt}, rx);
    endtask

    task automatic rd(input logic [2:0] ad);
        master.frame(16, {16'h0000, 1'b0, ad, 12'h000}, rx);
    endtask

    initial begin
        mismatches = 0;
        compares = 0;
        cycles = 0;
        strobes = 0;
        i_rst = 1'b1;
        hold = 1'b0;
        diag = 12'h3c5;
        for (int k = 0; k < 8; k++) exp_reg[k] = 12'h000;
        repeat (20) @(posedge i_clock);
        #1 i_rst = 1'b0;
        repeat (4) @(posedge i_clock);
        #1;
        check(regs, flat());
        wr(3'h0, ssfi_pkg::NOP_CMD);
        check(rx[15:0], resp(3'h0, diag));
        check(so_oe, 1'b0);
        $display("test reset_response done");

        for (int k = 1; k < 8; k++) begin
            a = k[2:0];
            d = 12'h9c3 ^ {a, a, a, a};
            diag = ~d;
            wr(a, d);
            exp_reg[k] = d;
            check(rx[15:0], resp(3'h0, diag));
            check(regs, flat());
            check(wr_addr, a);
        end
        check(strobes, 7);
        $display("test writes done");

        rd(3'h1);
        for (int k = 2; k < 9; k++) begin
            a = k[2:0];
            rd(a);
            check(rx[15:0], resp(3'(k - 1), exp_reg[k-1]));
        end
        $display("test reads done");

        master.frame(12, 32'h0000_0abc, rx);
        check(comm_err, 1'b1);
        check(regs, flat());
        master.tick(ssfi_pkg::OC_CLEAR_GAP_CYC);
        wr(3'h0, ssfi_pkg::READ_DIAG_STATUS_CMD);
        check(comm_err, 1'b0);
        master.tick(ssfi_pkg::DIAG_CLEAR_READ_CYC);
        wr(3'h0, ssfi_pkg::NOP_CMD);
        check(rx[15:0], resp(3'h0, {1'b1, diag[10:0]}));
        master.frame(0, 32'h0, rx);
        check(comm_err, 1'b1);
        wr(3'h0, ssfi_pkg::READ_DIAG_STATUS_CMD);
        check(comm_err, 1'b0);
        // Unknown code at the command address is refused
        wr(3'h0, 12'h0c3);
        check(comm_err, 1'b1);
        wr(3'h0, ssfi_pkg::READ_DIAG_STATUS_CMD);
        check(comm_err, 1'b0);
        $display("test bad_count done");

        master.wiggle();
        check(so_oe, 1'b0);
        check(comm_err, 1'b0);
        check(regs, flat());
        $display("test deselected done");

        master.frame(32, {16'hc3a5, 1'b1, 3'h5, 12'h7e1}, rx);
        exp_reg[5] = 12'h7e1;
        check(rx[31:16], resp(3'h0, {1'b1, diag[10:0]}));
        check(rx[14:0], 15'h61d2);
        check(regs, flat());
        $display("test chain done");

        // Upper byte: low short-diag bits, then the last latched bit of the chain frame
        diag = 12'h059;
        master.frame(8, 32'h0000_005c, rx);
        exp_reg[3] = 12'h35c;
        check(regs, flat());
        check(wr_addr, 3'h3);
        check(comm_err, 1'b0);
        $display("test byte_frame done");

        hold = 1'b1;
        wr(3'h1, 12'h0f0);
        wr(3'h2, 12'h00f);
        check(regs, flat());
        check(comm_err, 1'b0);
        wr(3'h6, 12'h555);
        check(comm_err, 1'b1);
        hold = 1'b0;
        master.tick(10);
        exp_reg[1] = 12'h0f0;
        exp_reg[2] = 12'h00f;
        check(regs, flat());
        check(strobes, 11);
        $display("test buffer done");
        test_done();
    end
endmodule

`default_nettype wire
